// ==== e1rx_pkg.sv ====
`default_nettype none
package e1rx_pkg;
    localparam int NCH = 22;
    localparam int CFG_W = 8;
    localparam int ADDR_W = 7;
    localparam int SLOT_W = 5;
    localparam int ACC_W = 16;
    localparam int IDX_W = 5;

    localparam logic [ADDR_W-1:0] ADDR_CFG_A_BASE = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_CFG_B_BASE = 7'h20;
    localparam logic [ADDR_W-1:0] ADDR_STREAM_CTRL = 7'h40;
    localparam logic [ADDR_W-1:0] ADDR_LOS_STAT0 = 7'h41;
    localparam logic [ADDR_W-1:0] ADDR_LOS_STAT1 = 7'h42;
    localparam logic [ADDR_W-1:0] ADDR_LOS_STAT2 = 7'h43;
    localparam logic [ADDR_W-1:0] NCH_SPAN = 7'h16;

    localparam int CFA_PWRDN = 0;
    localparam int CFA_FLOAT = 6;
    localparam int CFA_HOLD = 7;
    localparam int CFB_MODE_LSB = 0;
    localparam int CFB_INV = 3;
    localparam int CFB_EDGE = 4;
    localparam int CFB_SEL_LSB = 5;
    localparam int SCTL_EN = 0;
    localparam int SCTL_FAST = 1;
    localparam int LOS_B1_LSB = 8;
    localparam int LOS_B2_LSB = 16;
    localparam int LOS_B2_W = 6;

    localparam logic [CFG_W-1:0] CFG_A_RST = 8'h00;
    localparam logic [CFG_W-1:0] CFG_B_RST = 8'h10;

    // Clock rates in kHz; NCO steps toggle twice per output period
    localparam int SYS_CLK_KHZ = 40000;
    localparam int REF_CLK_KHZ = 2048;
    localparam int STREAM_FAST_KHZ = 2048;
    localparam int STREAM_SLOW_KHZ = 8;
    localparam logic [ACC_W-1:0] NCO_MOD = ACC_W'(SYS_CLK_KHZ);
    localparam logic [ACC_W-1:0] REF_STEP = ACC_W'(2 * REF_CLK_KHZ);
    localparam logic [ACC_W-1:0] FAST_STEP = ACC_W'(2 * STREAM_FAST_KHZ);
    localparam logic [ACC_W-1:0] SLOW_STEP = ACC_W'(2 * STREAM_SLOW_KHZ);

    localparam logic [SLOT_W-1:0] LOS_SLOTS = 5'h16;
    localparam logic [SLOT_W-1:0] PAD_SLOTS = 5'h07;
    localparam logic [SLOT_W-1:0] LAST_SLOT = LOS_SLOTS + PAD_SLOTS - 5'h01;

    typedef enum logic [1:0] {
        MODE_SR_NRZ = 2'h0,
        MODE_DR_NRZ = 2'h1,
        MODE_DR_RZ = 2'h2,
        MODE_DR_SLICED = 2'h3
    } e1rx_mode_t;

    typedef enum logic [2:0] {
        MF_PRBS = 3'h0,
        MF_AIS = 3'h1,
        MF_EXZ = 3'h2,
        MF_BPV = 3'h3,
        MF_EXZ_BPV = 3'h4,
        MF_LOS = 3'h5,
        MF_RCLK = 3'h6,
        MF_XOR = 3'h7
    } e1rx_mf_sel_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [CFG_W-1:0] wdata;
        logic wr;
        logic rd;
    } e1rx_bus_req_t;

    typedef struct packed {
        logic [NCH-1:0][CFG_W-1:0] cfg_a;
        logic [NCH-1:0][CFG_W-1:0] cfg_b;
        logic [NCH-1:0] rclk_prev;
        logic [NCH-1:0] pos_bit;
        logic [NCH-1:0] neg_bit;
        logic [NCH-1:0] mf;
        logic [NCH-1:0] pos_o;
        logic [NCH-1:0] neg_o;
        logic [NCH-1:0] clk_o;
        logic [NCH-1:0] oe;
        logic [ACC_W-1:0] ref_acc;
        logic ref_clk;
        logic en;
        logic fast;
        logic [ACC_W-1:0] s_acc;
        logic sclk;
        logic [SLOT_W-1:0] slot;
        logic los_o;
        logic mark_o;
        logic s_oe;
        logic [CFG_W-1:0] rdata;
    } e1rx_state_t;
endpackage
`default_nettype wire

// ==== e1rx_sysout.sv ====
// Summary of operation
// - Dual-rail modes drive positive and negative rails
// - Dual NRZ: undecoded rails retimed on edge
// - Dual RZ: undecoded RZ rails on edge
// - Sliced mode passes raw pulses untimed
// - Differential: tip-positive pulse on positive rail
// - Single-ended: tip positive pulse on positive rail
// - Invert bit b3 sets rail active level
// - Power down: outputs float or low, b6
// - Single NRZ: multifunction source by b7~5
// - Multifunction updates on edge (recovered clock source follows clock), active high
// - Clock pin carries recovered 2.048 MHz clock
// - Edge select b4 picks rising or falling
// - On LOS clock holds high or reference
// - Sliced mode: clock pin carries multifunction
// - Serial LOS streams all 22 channels
// - Seven low padding slots follow channels
// - Serial LOS updates on status rising edge
// - Serial LOS floats when stream disabled
// - Marker pulses once per 29 slots
// - Marker rising-edge updated, floats when disabled
// - Single NRZ: decoded data on active edge
// - Reference clock 2.048 MHz from master clock
`timescale 1ns/100ps
`default_nettype none
module e1rx_sysout
    import e1rx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire e1rx_bus_req_t i_bus,
    output logic [CFG_W-1:0] o_rdata,
    input wire logic [NCH-1:0] i_cdr_clk,
    input wire logic [NCH-1:0] i_slice_pos,
    input wire logic [NCH-1:0] i_slice_neg,
    input wire logic [NCH-1:0] i_rx_nrz_data,
    input wire logic [NCH-1:0] i_prbs_match,
    input wire logic [NCH-1:0] i_alarm_indication_flag,
    input wire logic [NCH-1:0] i_excess_zeros_flag,
    input wire logic [NCH-1:0] i_bipolar_violation_flag,
    input wire logic [NCH-1:0] i_line_los,
    output logic [NCH-1:0] o_rx_pos_rail,
    output logic [NCH-1:0] o_rx_neg_rail,
    output logic [NCH-1:0] o_rx_recovered_clk,
    output logic [NCH-1:0] o_rx_oe,
    output logic o_status_stream_clock,
    output logic o_serial_los_status,
    output logic o_serial_los_oe,
    output logic o_los_frame_marker,
    output logic o_los_frame_marker_oe
);
    e1rx_state_t st_q;
    e1rx_state_t st_d;

    always_comb begin
        logic pd;
        logic flt;
        logic inv;
        logic es;
        logic act_edge;
        logic rz_phase;
        logic src;
        logic [ACC_W-1:0] sum;
        logic [ACC_W-1:0] step;
        logic [ADDR_W-1:0] off;
        e1rx_mode_t mode;
        e1rx_mf_sel_t sel;
        pd = 1'b0;
        flt = 1'b0;
        inv = 1'b0;
        es = 1'b0;
        act_edge = 1'b0;
        rz_phase = 1'b0;
        src = 1'b0;
        sum = '0;
        step = '0;
        off = '0;
        mode = MODE_SR_NRZ;
        sel = MF_PRBS;
        st_d = st_q;

        // Register writes
        if (i_bus.wr) begin
            if (i_bus.addr >= ADDR_CFG_A_BASE && i_bus.addr < ADDR_CFG_A_BASE + NCH_SPAN) begin
                off = i_bus.addr - ADDR_CFG_A_BASE;
                st_d.cfg_a[off[IDX_W-1:0]] = i_bus.wdata;
            end else if (i_bus.addr >= ADDR_CFG_B_BASE && i_bus.addr < ADDR_CFG_B_BASE + NCH_SPAN) begin
                off = i_bus.addr - ADDR_CFG_B_BASE;
                st_d.cfg_b[off[IDX_W-1:0]] = i_bus.wdata;
            end else if (i_bus.addr == ADDR_STREAM_CTRL) begin
                st_d.en = i_bus.wdata[SCTL_EN];
                st_d.fast = i_bus.wdata[SCTL_FAST];
            end
        end

        // Read data stands only in the cycle after the strobe
        st_d.rdata = '0;
        if (i_bus.rd) begin
            if (i_bus.addr >= ADDR_CFG_A_BASE && i_bus.addr < ADDR_CFG_A_BASE + NCH_SPAN) begin
                off = i_bus.addr - ADDR_CFG_A_BASE;
                st_d.rdata = st_q.cfg_a[off[IDX_W-1:0]];
            end else if (i_bus.addr >= ADDR_CFG_B_BASE && i_bus.addr < ADDR_CFG_B_BASE + NCH_SPAN) begin
                off = i_bus.addr - ADDR_CFG_B_BASE;
                st_d.rdata = st_q.cfg_b[off[IDX_W-1:0]];
            end else if (i_bus.addr == ADDR_STREAM_CTRL) begin
                st_d.rdata[SCTL_EN] = st_q.en;
                st_d.rdata[SCTL_FAST] = st_q.fast;
            end else if (i_bus.addr == ADDR_LOS_STAT0) begin
                st_d.rdata = i_line_los[CFG_W-1:0];
            end else if (i_bus.addr == ADDR_LOS_STAT1) begin
                st_d.rdata = i_line_los[LOS_B1_LSB +: CFG_W];
            end else if (i_bus.addr == ADDR_LOS_STAT2) begin
                st_d.rdata[LOS_B2_W-1:0] = i_line_los[LOS_B2_LSB +: LOS_B2_W];
            end
        end

        // Fractional divider: 40 MHz is not a multiple of 2.048 MHz, so edges jitter by one cycle
        sum = st_q.ref_acc + REF_STEP;
        if (sum >= NCO_MOD) begin
            st_d.ref_acc = sum - NCO_MOD;
            st_d.ref_clk = ~st_q.ref_clk;
        end else begin
            st_d.ref_acc = sum;
        end

        // Per-channel receive output pins
        for (int c = 0; c < NCH; c++) begin
            pd = st_q.cfg_a[c][CFA_PWRDN];
            flt = st_q.cfg_a[c][CFA_FLOAT];
            inv = st_q.cfg_b[c][CFB_INV];
            es = st_q.cfg_b[c][CFB_EDGE];
            mode = e1rx_mode_t'(st_q.cfg_b[c][CFB_MODE_LSB +: 2]);
            sel = e1rx_mf_sel_t'(st_q.cfg_b[c][CFB_SEL_LSB +: 3]);
            st_d.rclk_prev[c] = i_cdr_clk[c];
            act_edge = es ? (i_cdr_clk[c] & ~st_q.rclk_prev[c]) : (~i_cdr_clk[c] & st_q.rclk_prev[c]);
            // RZ mark occupies the half period that follows the active edge
            rz_phase = ~(i_cdr_clk[c] ^ es);
            case (sel)
                MF_PRBS: src = i_prbs_match[c];
                MF_AIS: src = i_alarm_indication_flag[c];
                MF_EXZ: src = i_excess_zeros_flag[c];
                MF_BPV: src = i_bipolar_violation_flag[c];
                MF_EXZ_BPV: src = i_excess_zeros_flag[c] | i_bipolar_violation_flag[c];
                MF_LOS: src = i_line_los[c];
                MF_RCLK: src = i_cdr_clk[c];
                default: src = i_slice_pos[c] ^ i_slice_neg[c];
            endcase
            // Recovered clock as a source follows the clock itself, not an edge sample
            if (sel == MF_RCLK || act_edge) begin
                st_d.mf[c] = src;
            end
            if (act_edge) begin
                st_d.pos_bit[c] = i_slice_pos[c];
                st_d.neg_bit[c] = i_slice_neg[c];
            end
            if (pd) begin
                st_d.pos_o[c] = 1'b0;
                st_d.neg_o[c] = 1'b0;
                st_d.clk_o[c] = 1'b0;
                st_d.oe[c] = ~flt;
            end else begin
                st_d.oe[c] = 1'b1;
                case (mode)
                    MODE_SR_NRZ: begin
                        if (act_edge) begin
                            st_d.pos_o[c] = i_rx_nrz_data[c] ^ inv;
                        end
                        st_d.neg_o[c] = st_d.mf[c];
                    end
                    MODE_DR_NRZ: begin
                        if (act_edge) begin
                            st_d.pos_o[c] = i_slice_pos[c] ^ inv;
                            st_d.neg_o[c] = i_slice_neg[c] ^ inv;
                        end
                    end
                    MODE_DR_RZ: begin
                        st_d.pos_o[c] = (st_d.pos_bit[c] & rz_phase) ^ inv;
                        st_d.neg_o[c] = (st_d.neg_bit[c] & rz_phase) ^ inv;
                    end
                    default: begin
                        st_d.pos_o[c] = i_slice_pos[c] ^ inv;
                        st_d.neg_o[c] = i_slice_neg[c] ^ inv;
                    end
                endcase
                if (mode == MODE_DR_SLICED) begin
                    st_d.clk_o[c] = st_d.mf[c];
                end else if (i_line_los[c]) begin
                    st_d.clk_o[c] = st_q.cfg_a[c][CFA_HOLD] ? 1'b1 : st_q.ref_clk;
                end else begin
                    st_d.clk_o[c] = i_cdr_clk[c];
                end
            end
        end

        // Serial LOS stream, 29 status clock cycles per round
        st_d.s_oe = st_q.en;
        if (!st_q.en) begin
            st_d.s_acc = '0;
            st_d.sclk = 1'b0;
            st_d.slot = '0;
            st_d.los_o = 1'b0;
            st_d.mark_o = 1'b0;
        end else begin
            step = st_q.fast ? FAST_STEP : SLOW_STEP;
            sum = st_q.s_acc + step;
            if (sum >= NCO_MOD) begin
                st_d.s_acc = sum - NCO_MOD;
                st_d.sclk = ~st_q.sclk;
                if (!st_q.sclk) begin
                    st_d.mark_o = (st_q.slot == '0);
                    st_d.los_o = (st_q.slot < LOS_SLOTS) ? i_line_los[st_q.slot] : 1'b0;
                    st_d.slot = (st_q.slot == LAST_SLOT) ? '0 : st_q.slot + 5'h01;
                end
            end else begin
                st_d.s_acc = sum;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= '0;
            for (int c = 0; c < NCH; c++) begin
                st_q.cfg_a[c] <= CFG_A_RST;
                st_q.cfg_b[c] <= CFG_B_RST;
            end
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_rx_pos_rail = st_q.pos_o;
    assign o_rx_neg_rail = st_q.neg_o;
    assign o_rx_recovered_clk = st_q.clk_o;
    assign o_rx_oe = st_q.oe;
    assign o_status_stream_clock = st_q.sclk;
    assign o_serial_los_status = st_q.los_o;
    assign o_serial_los_oe = st_q.s_oe;
    assign o_los_frame_marker = st_q.mark_o;
    assign o_los_frame_marker_oe = st_q.s_oe;

    // Channel 0 views for checking
    logic ch0_pd;
    logic ch0_flt;
    logic ch0_inv;
    logic ch0_hold;
    e1rx_mode_t ch0_mode;
    assign ch0_pd = st_q.cfg_a[0][CFA_PWRDN];
    assign ch0_flt = st_q.cfg_a[0][CFA_FLOAT];
    assign ch0_hold = st_q.cfg_a[0][CFA_HOLD];
    assign ch0_inv = st_q.cfg_b[0][CFB_INV];
    assign ch0_mode = e1rx_mode_t'(st_q.cfg_b[0][CFB_MODE_LSB +: 2]);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    property p_mark_slot;
        st_q.s_oe && st_q.mark_o |-> st_q.slot == 5'h01;
    endproperty
    a_mark_slot: assert property (p_mark_slot) else $error("marker outside channel 0 slot");

    property p_pad_low;
        st_q.s_oe && (st_q.slot == 5'h00 || st_q.slot > LOS_SLOTS) |-> !st_q.los_o;
    endproperty
    a_pad_low: assert property (p_pad_low) else $error("padding slot not low");

    property p_los_on_rise;
        st_q.s_oe && $changed(st_q.los_o) && $past(st_q.en) |-> $rose(st_q.sclk);
    endproperty
    a_los_on_rise: assert property (p_los_on_rise) else $error("serial LOS moved off rising edge");

    property p_stream_float;
        !st_q.en |=> !o_serial_los_oe && !o_los_frame_marker_oe;
    endproperty
    a_stream_float: assert property (p_stream_float) else $error("stream pins driven while disabled");

    property p_ch_slot_map;
        st_q.en && $rose(st_q.sclk) && st_q.slot >= 5'h01 && st_q.slot <= LOS_SLOTS
            |-> st_q.los_o == $past(i_line_los[st_q.slot]);
    endproperty
    a_ch_slot_map: assert property (p_ch_slot_map) else $error("channel bit in wrong slot");

    property p_pd_float;
        ch0_pd && ch0_flt |=> !o_rx_oe[0];
    endproperty
    a_pd_float: assert property (p_pd_float) else $error("powered-down pins not floating");

    property p_pd_low;
        ch0_pd && !ch0_flt |=> o_rx_oe[0] && !o_rx_pos_rail[0] && !o_rx_neg_rail[0] && !o_rx_recovered_clk[0];
    endproperty
    a_pd_low: assert property (p_pd_low) else $error("powered-down pins not low");

    property p_los_hold;
        !ch0_pd && ch0_mode != MODE_DR_SLICED && i_line_los[0] && ch0_hold |=> o_rx_recovered_clk[0];
    endproperty
    a_los_hold: assert property (p_los_hold) else $error("clock not held high on LOS");

    property p_clk_follow;
        !ch0_pd && ch0_mode != MODE_DR_SLICED && !i_line_los[0] |=> o_rx_recovered_clk[0] == $past(i_cdr_clk[0]);
    endproperty
    a_clk_follow: assert property (p_clk_follow) else $error("clock pin not recovered clock");

    property p_sliced_pass;
        !ch0_pd && ch0_mode == MODE_DR_SLICED |=> o_rx_pos_rail[0] == $past(i_slice_pos[0] ^ ch0_inv);
    endproperty
    a_sliced_pass: assert property (p_sliced_pass) else $error("sliced pulse not passed");

    property p_sliced_clk_mf;
        !ch0_pd && ch0_mode == MODE_DR_SLICED |=> o_rx_recovered_clk[0] == st_q.mf[0];
    endproperty
    a_sliced_clk_mf: assert property (p_sliced_clk_mf) else $error("clock pin not multifunction");

    c_marker: cover property (st_q.s_oe && $rose(st_q.mark_o));
    c_pd_float: cover property (ch0_pd && ch0_flt ##1 !o_rx_oe[0]);
    c_los_ref: cover property (!ch0_pd && i_line_los[0] && !ch0_hold);
    c_sliced: cover property (!ch0_pd && ch0_mode == MODE_DR_SLICED);
endmodule
`default_nettype wire

// ==== e1rx_los_rcvr.sv ====
`timescale 1ns/100ps
`default_nettype none
module e1rx_los_rcvr
    import e1rx_pkg::*;
(
    input wire logic i_sclk,
    input wire logic i_los,
    input wire logic i_mark,
    output logic [NCH-1:0] o_frame,
    output logic [7:0] o_frames,
    output logic [7:0] o_period,
    output logic o_pad_bad
);
    logic [NCH-1:0] vec;
    logic [7:0] cnt;
    int slot;
    initial begin
        vec = '0;
        cnt = 8'h00;
        slot = 99;
        o_frame = '0;
        o_frames = 8'h00;
        o_period = 8'h00;
        o_pad_bad = 1'b0;
    end
    // Sample on the falling edge, clear of the launching rising edge
    always @(negedge i_sclk) begin
        if (i_mark === 1'b1) begin
            slot = 0;
            o_period = cnt;
            cnt = 8'h01;
        end else begin
            slot = (slot >= 99) ? 99 : slot + 1;
            cnt = cnt + 8'h01;
        end
        if (slot < NCH) begin
            vec[slot] = i_los;
        end else if (slot < 29 && i_los !== 1'b0) begin
            o_pad_bad = 1'b1;
        end
        if (slot == NCH - 1) begin
            o_frame = vec;
            o_frames = o_frames + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== e1rx_sysout_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module e1rx_sysout_tb
    import e1rx_pkg::*;
;
    logic i_clk, i_sys_rst, cdr;
    e1rx_bus_req_t i_bus;
    logic [3:0] cc;
    logic [NCH-1:0] sp, sn, nrz, prbs, ais, exz, bpv, los, pos, neg, rck, oe, frame;
    logic [CFG_W-1:0] rdata;
    logic sclk, slos, soe, mark, moe, pad_bad;
    logic [7:0] frames, period;
    int fails = 0;
    int comparisons = 0;
    e1rx_sysout u_e1rx_sysout (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(rdata),
        .i_cdr_clk({NCH{cdr}}), .i_slice_pos(sp), .i_slice_neg(sn), .i_rx_nrz_data(nrz), .i_prbs_match(prbs),
        .i_alarm_indication_flag(ais), .i_excess_zeros_flag(exz), .i_bipolar_violation_flag(bpv),
        .i_line_los(los), .o_rx_pos_rail(pos), .o_rx_neg_rail(neg), .o_rx_recovered_clk(rck), .o_rx_oe(oe),
        .o_status_stream_clock(sclk), .o_serial_los_status(slos), .o_serial_los_oe(soe),
        .o_los_frame_marker(mark), .o_los_frame_marker_oe(moe));
    e1rx_los_rcvr u_e1rx_los_rcvr (.i_sclk(sclk), .i_los(slos), .i_mark(mark), .o_frame(frame),
        .o_frames(frames), .o_period(period), .o_pad_bad(pad_bad));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // Recovered clock near 2 MHz, free of any lock to the status clock
    always @(posedge i_clk) begin
        cc <= (cc == 4'h9) ? 4'h0 : cc + 4'h1;
        if (cc == 4'h9) begin
            cdr <= ~cdr;
        end
    end
    task close_out;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [23:0] g, input logic [23:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [CFG_W-1:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
    endtask
    task rd(input logic [ADDR_W-1:0] a, input logic [CFG_W-1:0] e);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1 chk(rdata, e);
    endtask
    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (cdr !== v && n < 50) begin
            @(posedge i_clk);
            #1 n++;
        end
        if (n >= 50) begin
            fails++;
            close_out();
        end
    endtask
    // Outputs settle a few system cycles after the recovered clock edge
    task wrise;
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    task t_regs;
        rd(ADDR_CFG_A_BASE, CFG_A_RST);
        rd(ADDR_CFG_B_BASE + 7'h15, CFG_B_RST);
        wr(7'h7F, 8'hAA);
        rd(7'h7F, 8'h00);
        wr(ADDR_CFG_A_BASE + 7'h15, 8'h80);
        rd(ADDR_CFG_A_BASE + 7'h15, 8'h80);
    endtask
    task t_mf;
        logic [NCH-1:0] vv;
        for (int s = 0; s < 8; s++) begin
            if (s != 6) begin
                wr(ADDR_CFG_B_BASE, {s[2:0], 5'h18});
                for (int v = 0; v < 2; v++) begin
                    vv = {NCH{v[0]}};
                    @(posedge i_clk);
                    prbs <= (s == 0) ? vv : '1;
                    ais <= (s == 1) ? vv : '1;
                    exz <= (s == 2 || s == 4) ? vv : '1;
                    bpv <= (s == 3 || s == 4) ? vv : '1;
                    los <= (s == 5) ? vv : '0;
                    sp <= '1;
                    sn <= (s == 7) ? ~vv : '1;
                    nrz <= vv;
                    wrise();
                    chk(neg[0], v[0]);
                    chk(pos[0], !v[0]);
                end
            end
        end
    endtask
    task t_edge;
        wr(ADDR_CFG_B_BASE, 8'h10);
        @(posedge i_clk);
        nrz <= '1;
        wrise();
        @(posedge i_clk);
        nrz <= '0;
        wait_lvl(1'b0);
        repeat (4) @(posedge i_clk);
        #1 chk(pos[0], 1'b1);
        wrise();
        chk(pos[0], 1'b0);
        wr(ADDR_CFG_B_BASE, 8'h00);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        @(posedge i_clk);
        nrz <= '1;
        repeat (4) @(posedge i_clk);
        #1 chk(pos[0], 1'b0);
        wait_lvl(1'b0);
        repeat (4) @(posedge i_clk);
        #1 chk(pos[0], 1'b1);
    endtask
    task t_dual;
        wr(ADDR_CFG_B_BASE, 8'h11);
        for (int v = 0; v < 2; v++) begin
            @(posedge i_clk);
            sp <= {NCH{v[0]}};
            sn <= {NCH{~v[0]}};
            wrise();
            chk({pos[0], neg[0]}, {v[0], ~v[0]});
        end
        wr(ADDR_CFG_B_BASE, 8'hF3);
        @(posedge i_clk);
        sn <= '1;
        wrise();
        chk({pos[0], neg[0], rck[0]}, 3'h6);
        @(posedge i_clk);
        sn <= '0;
        wrise();
        chk({pos[0], neg[0], rck[0]}, 3'h5);
        wr(ADDR_CFG_B_BASE, 8'h10);
    endtask
    task t_pwr;
        @(posedge i_clk);
        nrz <= '1;
        wr(ADDR_CFG_A_BASE + 7'h03, 8'h01);
        repeat (3) @(posedge i_clk);
        #1 chk({oe[3], pos[3], neg[3], rck[3]}, 4'h8);
        wr(ADDR_CFG_A_BASE + 7'h03, 8'h41);
        repeat (3) @(posedge i_clk);
        #1 chk(oe[3], 1'b0);
        wr(ADDR_CFG_A_BASE + 7'h03, 8'h00);
        repeat (3) @(posedge i_clk);
        #1 chk(oe[3], 1'b1);
    endtask
    task t_los;
        logic h, p;
        int tog;
        h = 1'b1;
        tog = 0;
        wr(ADDR_CFG_A_BASE + 7'h01, 8'h80);
        @(posedge i_clk);
        los <= 22'h0ACE6;
        repeat (4) @(posedge i_clk);
        #1 p = rck[2];
        for (int i = 0; i < 60; i++) begin
            @(posedge i_clk);
            #1 h = h & (rck[1] === 1'b1);
            tog += (rck[2] !== p);
            p = rck[2];
        end
        chk(h, 1'b1);
        chk(tog >= 4, 1'b1);
    endtask
    task t_stream;
        int n;
        chk({soe, moe}, 2'h0);
        wr(ADDR_STREAM_CTRL, 8'h03);
        repeat (2) @(posedge i_clk);
        #1 chk({soe, moe}, 2'h3);
        n = 0;
        while (frames < 8'h02 && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        chk(n < 3000, 1'b1);
        chk(frame, los);
        chk(period, 8'd29);
        chk(pad_bad, 1'b0);
        wr(ADDR_STREAM_CTRL, 8'h00);
        repeat (3) @(posedge i_clk);
        #1 chk({soe, moe, sclk}, 3'h0);
    endtask
    initial begin
        i_sys_rst = 1'b1;
        i_bus = '0;
        cdr = 1'b0;
        cc = 4'h0;
        {sp, sn, nrz, prbs, ais, exz, bpv, los} = '0;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_regs();
        t_mf();
        t_edge();
        t_dual();
        t_pwr();
        t_los();
        t_stream();
        close_out();
    end
endmodule
`default_nettype wire
